/* File: inc/tccmp_pkg.sv */
`default_nettype none
package tccmp_pkg;
  // Widths and counts
  localparam int TCCMP_W   = 16;
  localparam int TCCMP_NT  = 2;
  localparam int TCCMP_NCH = 4;
  // Match output action codes
  localparam logic [1:0] TCCMP_EMC_NONE = 2'h0;
  localparam logic [1:0] TCCMP_EMC_CLR  = 2'h1;
  localparam logic [1:0] TCCMP_EMC_SET  = 2'h2;
  localparam logic [1:0] TCCMP_EMC_TGL  = 2'h3;
  // Count source modes
  localparam logic [1:0] TCCMP_CNT_TIMER = 2'h0;
  localparam logic [1:0] TCCMP_CNT_RISE  = 2'h1;
  localparam logic [1:0] TCCMP_CNT_FALL  = 2'h2;
  localparam logic [1:0] TCCMP_CNT_BOTH  = 2'h3;
  // Field positions inside a channel's match control
  localparam int TCCMP_MC_INT  = 0;
  localparam int TCCMP_MC_RST  = 1;
  localparam int TCCMP_MC_STOP = 2;
  // Field positions inside a channel's capture control
  localparam int TCCMP_CC_RISE = 0;
  localparam int TCCMP_CC_FALL = 1;
  localparam int TCCMP_CC_INT  = 2;
  // Capture flags sit above the match flags
  localparam int TCCMP_IR_CAP = 4;
  // Steps and reset values
  localparam logic [15:0] TCCMP_ONE    = 16'h0001;
  localparam logic [15:0] TCCMP_ZERO   = 16'h0000;
  localparam logic [3:0]  TCCMP_NO_CAP = 4'h0;

  // Software-facing settings of one timer
  typedef struct packed {
    logic             enable;
    logic             cnt_reset;
    logic [1:0]       count_mode;
    logic [1:0]       count_input;
    logic [15:0]      prescale_limit;
    logic [3:0][15:0] match_value;
    logic [3:0][2:0]  match_ctrl;
    logic [3:0][2:0]  capture_ctrl;
    logic [3:0][1:0]  external_match_control;
    logic [3:0]       pwm_mode_control;
    logic [7:0]       flag_clear;
  } tccmp_cfg_t;

  // Observable state of one timer
  typedef struct packed {
    logic [15:0]      timer_count;
    logic [15:0]      prescale_count;
    logic [3:0][15:0] capture_value;
    logic [7:0]       interrupt_flags;
    logic [3:0]       ext_match;
    logic             halted;
  } tccmp_tmr_t;

  // Whole state of the block
  typedef struct packed {
    tccmp_tmr_t [1:0]  tmr;
    logic [1:0][3:0]   cap_prev;
  } tccmp_state_t;

  localparam tccmp_state_t TCCMP_STATE_RST = '0;
endpackage
`default_nettype wire

/* File: src/tccmp_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tccmp_top (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire tccmp_pkg::tccmp_cfg_t cfg_t2,
  input  wire tccmp_pkg::tccmp_cfg_t cfg_t3,
  input  wire logic               capture_in_t2_ch0,
  input  wire logic               capture_in_t2_ch1,
  input  wire logic               capture_in_t2_ch2,
  output logic                    match_out_t2_ch0,
  output logic                    match_out_t2_ch1,
  output logic                    match_out_t2_ch2,
  output logic                    match_out_t3_ch0,
  output logic                    match_out_t3_ch1,
  output logic                    match_out_t3_ch2,
  output logic                    match_out_t3_ch3,
  output tccmp_pkg::tccmp_tmr_t   status_t2,
  output tccmp_pkg::tccmp_tmr_t   status_t3
);

  ////////////////////////////////////////////////////////////////////////////
  // State and wiring

  tccmp_pkg::tccmp_state_t      state_r;   // Every flip-flop of the block
  tccmp_pkg::tccmp_state_t      state_nxt; // Next value of the above
  tccmp_pkg::tccmp_cfg_t  [1:0] cfg;       // Index 0 is timer 2
  logic                   [1:0][3:0] cap_in; // Capture levels per timer

  // Edge test shared by count source and capture channels
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rise, input logic fall);
    edge_hit = (rise && !prev && cur) || (fall && prev && !cur);
  endfunction

  // Both instances share one body; they differ only in wiring
  // identical instances
  assign cfg = {cfg_t3, cfg_t2};
  // Timer 2 has three capture pins; its fourth and all of timer 3 read low
  // capture pinout
  assign cap_in[0] = {1'b0, capture_in_t2_ch2, capture_in_t2_ch1, capture_in_t2_ch0};
  assign cap_in[1] = tccmp_pkg::TCCMP_NO_CAP;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for both timers

  always_comb begin
    tccmp_pkg::tccmp_cfg_t c;
    tccmp_pkg::tccmp_tmr_t s;
    tccmp_pkg::tccmp_tmr_t q;
    logic                  tick;
    logic                  wrap;
    logic                  rst;
    logic                  stop;
    logic [3:0]            hit;
    c = '0;
    s = '0;
    q = '0;
    tick = 1'b0;
    wrap = 1'b0;
    rst = 1'b0;
    stop = 1'b0;
    hit = '0;
    state_nxt = state_r;
    for (int t = 0; t < tccmp_pkg::TCCMP_NT; t++) begin
      c = cfg[t];
      q = state_r.tmr[t];
      s = q;
      // Count source: every clock, or edges of a chosen capture input
      // timer or counter
      if (c.count_mode == tccmp_pkg::TCCMP_CNT_TIMER) begin
        tick = 1'b1;
      end else begin
        tick = edge_hit(state_r.cap_prev[t][c.count_input],
                        cap_in[t][c.count_input], c.count_mode[0], c.count_mode[1]);
      end
      // Prescaler wrap marks the last cycle of a counter value
      wrap = tick && c.enable && !q.halted && !c.cnt_reset &&
             (q.prescale_count == c.prescale_limit);
      rst = 1'b0;
      stop = 1'b0;
      // Compare only on the wrap so each value matches once
      // one event per value
      for (int m = 0; m < tccmp_pkg::TCCMP_NCH; m++) begin
        hit[m] = wrap && (q.timer_count == c.match_value[m]);
        rst = rst || (hit[m] && c.match_ctrl[m][tccmp_pkg::TCCMP_MC_RST]);
        stop = stop || (hit[m] && c.match_ctrl[m][tccmp_pkg::TCCMP_MC_STOP]);
      end
      // Clear first so a same-cycle set is not lost
      // write clears flags
      s.interrupt_flags = q.interrupt_flags & ~c.flag_clear;
      for (int m = 0; m < tccmp_pkg::TCCMP_NCH; m++) begin
        if (hit[m] && c.match_ctrl[m][tccmp_pkg::TCCMP_MC_INT]) begin
          s.interrupt_flags[m] = 1'b1;
        end
      end
      // Counter and prescaler
      if (c.cnt_reset) begin
        // Held reset also releases a stop
        s.timer_count = tccmp_pkg::TCCMP_ZERO;
        s.prescale_count = tccmp_pkg::TCCMP_ZERO;
        s.halted = 1'b0;
      end else if (!c.enable) begin
        // Dropping enable re-arms a stopped counter
        s.halted = 1'b0;
      end else if (tick && !q.halted) begin
        if (wrap) begin
          s.prescale_count = tccmp_pkg::TCCMP_ZERO;
          if (rst) begin
            s.timer_count = tccmp_pkg::TCCMP_ZERO;
          end else if (!stop) begin
            s.timer_count = q.timer_count + tccmp_pkg::TCCMP_ONE;
          end
          s.halted = stop;
        end else begin
          s.prescale_count = q.prescale_count + tccmp_pkg::TCCMP_ONE;
        end
      end
      // Match outputs, either action-coded or PWM
      // joint control
      for (int m = 0; m < tccmp_pkg::TCCMP_NCH; m++) begin
        if (c.pwm_mode_control[m]) begin
          // Period restart lowers it; a zero match keeps it high for good
          // PWM edges
          if (rst && (c.match_value[m] != tccmp_pkg::TCCMP_ZERO)) begin
            s.ext_match[m] = 1'b0;
          end
          if (hit[m]) begin
            s.ext_match[m] = 1'b1;
          end
        end else if (hit[m]) begin
          unique case (c.external_match_control[m])
            tccmp_pkg::TCCMP_EMC_NONE: s.ext_match[m] = q.ext_match[m];
            tccmp_pkg::TCCMP_EMC_CLR:  s.ext_match[m] = 1'b0;
            tccmp_pkg::TCCMP_EMC_SET:  s.ext_match[m] = 1'b1;
            tccmp_pkg::TCCMP_EMC_TGL:  s.ext_match[m] = !q.ext_match[m];
          endcase
        end
      end
      // Capture channels latch the value held before this edge
      // four captures
      for (int k = 0; k < tccmp_pkg::TCCMP_NCH; k++) begin
        if (edge_hit(state_r.cap_prev[t][k], cap_in[t][k],
                     c.capture_ctrl[k][tccmp_pkg::TCCMP_CC_RISE],
                     c.capture_ctrl[k][tccmp_pkg::TCCMP_CC_FALL])) begin
          s.capture_value[k] = q.timer_count;
          if (c.capture_ctrl[k][tccmp_pkg::TCCMP_CC_INT]) begin
            s.interrupt_flags[tccmp_pkg::TCCMP_IR_CAP + k] = 1'b1;
          end
        end
      end
      state_nxt.tmr[t] = s;
      state_nxt.cap_prev[t] = cap_in[t];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset to constants
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_r <= tccmp_pkg::TCCMP_STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign status_t2 = state_r.tmr[0];
  assign status_t3 = state_r.tmr[1];
  // Timer 2 drives three pins, timer 3 all four; PWM period best on the fourth
  // three PWM pins
  assign match_out_t2_ch0 = state_r.tmr[0].ext_match[0];
  assign match_out_t2_ch1 = state_r.tmr[0].ext_match[1];
  assign match_out_t2_ch2 = state_r.tmr[0].ext_match[2];
  assign match_out_t3_ch0 = state_r.tmr[1].ext_match[0];
  assign match_out_t3_ch1 = state_r.tmr[1].ext_match[1];
  assign match_out_t3_ch2 = state_r.tmr[1].ext_match[2];
  assign match_out_t3_ch3 = state_r.tmr[1].ext_match[3];

  ////////////////////////////////////////////////////////////////////////////
  // Checks on timer 2, all but the capture and flag clear ones in clock mode, plus one on timer 3 captures

  tccmp_pkg::tccmp_tmr_t t2;     // Timer 2 state view
  logic                  run2;   // Timer 2 advancing this cycle
  logic                  wrap2;  // Timer 2 prescaler wrap
  assign t2 = state_r.tmr[0];
  assign run2 = (cfg_t2.count_mode == tccmp_pkg::TCCMP_CNT_TIMER) && cfg_t2.enable &&
                !cfg_t2.cnt_reset && !t2.halted;
  assign wrap2 = run2 && (t2.prescale_count == cfg_t2.prescale_limit);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_prescale_wrap: assert property (
    wrap2 |=> (t2.prescale_count == 16'h0000))
    else $error("prescaler did not clear at its limit");
  chk_count_hold: assert property (
    run2 && !wrap2 |=> $stable(t2.timer_count) &&
      (t2.prescale_count == $past(t2.prescale_count) + 16'h0001))
    else $error("counter moved before prescaler wrap");
  chk_match_reset: assert property (
    wrap2 && (t2.timer_count == cfg_t2.match_value[0]) && cfg_t2.match_ctrl[0][1]
      |=> (t2.timer_count == 16'h0000))
    else $error("match reset did not zero the counter");
  chk_match_stop: assert property (
    wrap2 && (t2.timer_count == cfg_t2.match_value[1]) && cfg_t2.match_ctrl[1][2]
      ##1 cfg_t2.enable && !cfg_t2.cnt_reset |=> t2.halted && $stable(t2.timer_count))
    else $error("match stop did not halt the counter");
  chk_match_flag: assert property (
    wrap2 && (t2.timer_count == cfg_t2.match_value[2]) && cfg_t2.match_ctrl[2][0]
      |=> t2.interrupt_flags[2])
    else $error("match flag not raised");
  chk_flag_clear: assert property (
    cfg_t2.flag_clear[3] && !(wrap2 && (t2.timer_count == cfg_t2.match_value[3]))
      |=> !t2.interrupt_flags[3])
    else $error("flag clear ignored");
  chk_ext_toggle: assert property (
    wrap2 && (t2.timer_count == cfg_t2.match_value[0]) && !cfg_t2.pwm_mode_control[0] &&
      (cfg_t2.external_match_control[0] == 2'h3) |=> (t2.ext_match[0] != $past(t2.ext_match[0])))
    else $error("toggle action did not invert output");
  chk_pwm_high: assert property (
    wrap2 && (t2.timer_count == cfg_t2.match_value[1]) && cfg_t2.pwm_mode_control[1]
      |=> match_out_t2_ch1)
    else $error("PWM output not high after its match");
  chk_capture_load: assert property (
    !state_r.cap_prev[0][0] && capture_in_t2_ch0 && cfg_t2.capture_ctrl[0][0]
      |=> (t2.capture_value[0] == $past(t2.timer_count)))
    else $error("capture did not latch the count");
  chk_t3_nocap: assert property (
    state_r.tmr[1].capture_value == '0)
    else $error("unpinned capture loaded a value");

endmodule
`default_nettype wire

/* File: test/tccmp_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far side of timer 2: drives the three capture pins as synchronous levels
module tccmp_pin_model (
  input  wire logic       clk_sys,
  input  wire logic [2:0] level_req,
  output logic            capture_in_t2_ch0,
  output logic            capture_in_t2_ch1,
  output logic            capture_in_t2_ch2
);
  // Pins change only on a clock edge, so the block never sees a glitch
  always_ff @(posedge clk_sys) begin
    capture_in_t2_ch0 <= level_req[0];
    capture_in_t2_ch1 <= level_req[1];
    capture_in_t2_ch2 <= level_req[2];
  end
endmodule
`default_nettype wire

/* File: test/tccmp_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tccmp_top_tb_top;
  typedef struct packed {logic [1:0] code; logic exp_out;} tccmp_row_t;
  logic                  clk_sys = 1'b0;  // 100 MHz clock
  logic                  reset_n = 1'b0;  // Sync reset, active low
  tccmp_pkg::tccmp_cfg_t c2      = '0;    // Timer 2 settings
  tccmp_pkg::tccmp_cfg_t c3      = '0;    // Timer 3 settings
  tccmp_pkg::tccmp_tmr_t s2;              // Timer 2 status
  tccmp_pkg::tccmp_tmr_t s3;              // Timer 3 status
  logic [2:0]            pin_req = 3'h0;  // Requested capture levels
  wire logic [2:0]       cap;             // Capture pins
  wire logic [2:0]       m2;              // Timer 2 match pins
  wire logic [3:0]       m3;              // Timer 3 match pins
  int                    fail_count = 0;
  int                    tests_run  = 0;
  int                    cycles     = 0;
  int                    i;
  // Action code rows: a match every period, output after it
  tccmp_row_t rows [5] = '{'{tccmp_pkg::TCCMP_EMC_SET, 1'b1}, '{tccmp_pkg::TCCMP_EMC_NONE, 1'b1},
    '{tccmp_pkg::TCCMP_EMC_CLR, 1'b0}, '{tccmp_pkg::TCCMP_EMC_TGL, 1'b1},
    '{tccmp_pkg::TCCMP_EMC_TGL, 1'b0}};
////////////////////////////////////////////////////////////////////////////////
  always #5 clk_sys = ~clk_sys;
  tccmp_pin_model pins_u (.clk_sys(clk_sys), .level_req(pin_req), .capture_in_t2_ch0(cap[0]),
    .capture_in_t2_ch1(cap[1]), .capture_in_t2_ch2(cap[2]));
  tccmp_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .cfg_t2(c2), .cfg_t3(c3),
    .capture_in_t2_ch0(cap[0]), .capture_in_t2_ch1(cap[1]), .capture_in_t2_ch2(cap[2]),
    .match_out_t2_ch0(m2[0]), .match_out_t2_ch1(m2[1]), .match_out_t2_ch2(m2[2]),
    .match_out_t3_ch0(m3[0]), .match_out_t3_ch1(m3[1]), .match_out_t3_ch2(m3[2]),
    .match_out_t3_ch3(m3[3]), .status_t2(s2), .status_t3(s3));
////////////////////////////////////////////////////////////////////////////////
  // Whole run needs well under a thousand cycles; the ceiling leaves margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs always move 1 ns after the rising edge
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait for a count value on timer 2 or timer 3
  task wait_cnt(input logic t3, input logic [15:0] v);
    int k;
    for (k = 0; k < 200 && (t3 ? s3.timer_count : s2.timer_count) !== v; k++) tick(1);
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    reset_n = 1'b1;
    check("reset count", s2.timer_count, 16'h0000);
    check("reset flags", {8'h00, s3.interrupt_flags}, 16'h0000);
    // Timer 3 period of four counts set by the fourth match
    // fourth match sets period
    c3.match_value[3] = 16'h0003;
    c3.match_ctrl[3] = 3'h2;
    c3.match_value[0] = 16'h0001;
    c3.enable = 1'b1;
    // Channels two and three latch high on their first match
    c3.external_match_control[2] = tccmp_pkg::TCCMP_EMC_SET;
    c3.external_match_control[3] = tccmp_pkg::TCCMP_EMC_SET;
    for (i = 0; i < 5; i++) begin
      c3.external_match_control[0] = rows[i].code;
      tick(4);
      check("action out", {15'h0000, m3[0]}, {15'h0000, rows[i].exp_out});
    end
    check("upper pins", {14'h0000, m3[3], m3[2]}, 16'h0003);
    // PWM on channel 1, period ten counts, edge at four
    c3.match_value[3] = 16'h0009;
    c3.match_value[1] = 16'h0004;
    c3.pwm_mode_control[1] = 1'b1;
    wait_cnt(1'b1, 16'h0009);
    wait_cnt(1'b1, 16'h0002);
    check("pwm low", {15'h0000, m3[1]}, 16'h0000);
    wait_cnt(1'b1, 16'h0006);
    check("pwm high", {15'h0000, m3[1]}, 16'h0001);
    // Prescaler of two: one count every three cycles
    c2.prescale_limit = 16'h0002;
    c2.enable = 1'b1;
    wait_cnt(1'b0, 16'h0001);
    tick(3);
    check("prescale step", s2.timer_count, 16'h0002);
    // Reset and flag on match six, then clear the flag
    c2.match_value[0] = 16'h0006;
    c2.match_ctrl[0] = 3'h3;
    // Channel 0 toggles on the reset match; channel 2 flags and sets at four
    c2.external_match_control[0] = tccmp_pkg::TCCMP_EMC_TGL;
    c2.match_value[2] = 16'h0004;
    c2.match_ctrl[2] = 3'h1;
    c2.external_match_control[2] = tccmp_pkg::TCCMP_EMC_SET;
    wait_cnt(1'b0, 16'h0006);
    tick(3);
    check("match reset", s2.timer_count, 16'h0000);
    check("match flag", {8'h00, s2.interrupt_flags}, 16'h0005);
    check("t2 pins", {13'h0000, m2}, 16'h0005);
    c2.flag_clear = 8'h0f;
    tick(1);
    c2.flag_clear = 8'h00;
    check("flag clear", {8'h00, s2.interrupt_flags}, 16'h0000);
    // Stop on match three; the frozen count then feeds a capture
    c2.match_ctrl[0] = 3'h0;
    c2.match_value[1] = 16'h0003;
    c2.match_ctrl[1] = 3'h4;
    c2.pwm_mode_control[1] = 1'b1;
    wait_cnt(1'b0, 16'h0003);
    tick(10);
    check("stop count", s2.timer_count, 16'h0003);
    check("halted", {15'h0000, s2.halted}, 16'h0001);
    check("t2 pwm high", {15'h0000, m2[1]}, 16'h0001);
    c2.capture_ctrl[0] = 3'h5;
    pin_req[0] = 1'b1;
    tick(4);
    check("capture value", s2.capture_value[0], 16'h0003);
    check("capture flag", {8'h00, s2.interrupt_flags}, 16'h0010);
    // Counter mode: rising edges of capture channel 1 drive the count
    c2.cnt_reset = 1'b1;
    c2.match_ctrl[1] = 3'h0;
    c2.prescale_limit = 16'h0000;
    c2.count_mode = tccmp_pkg::TCCMP_CNT_RISE;
    c2.count_input = 2'h1;
    tick(1);
    c2.cnt_reset = 1'b0;
    repeat (5) begin
      pin_req[1] = 1'b1;
      tick(3);
      pin_req[1] = 1'b0;
      tick(3);
    end
    check("edge count", s2.timer_count, 16'h0005);
    // Reset in mid-run clears counters, captures and pins, then timer 3 restarts
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    check("rerun count", s3.timer_count, 16'h0000);
    check("rerun capture", s2.capture_value[0], 16'h0000);
    check("rerun pins", {9'h000, m3, m2}, 16'h0000);
    tick(2);
    check("rerun restart", s3.timer_count, 16'h0002);
    give_verdict();
  end
endmodule
`default_nettype wire
